// ---- common/slcr_pkg.sv ----
// Constants, types and address decode shared by the serial lane config block
package slcr_pkg;
   // Widths and counts
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int NREGS = 7;
   localparam int NLANES = 4;
   localparam int SAMP_W = 8;
   localparam int LANE_W = 16;
   localparam int DE_W = 6;

   // Register indices as printed; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_DEEMPH_S0 = 8'h12;
   localparam logic [ADDR_W-1:0] IDX_DEEMPH_S1 = 8'h13;
   localparam logic [ADDR_W-1:0] IDX_DEEMPH_S2 = 8'h14;
   localparam logic [ADDR_W-1:0] IDX_DEEMPH_S3 = 8'h15;
   localparam logic [ADDR_W-1:0] IDX_PAIRING = 8'h16;
   localparam logic [ADDR_W-1:0] IDX_MAP_A = 8'h31;
   localparam logic [ADDR_W-1:0] IDX_MAP_B = 8'h32;
   localparam int BYTE_SHIFT = 2;

   // Storage slots inside the register memory
   localparam logic [2:0] SLOT_DE0 = 3'h0;
   localparam logic [2:0] SLOT_DE1 = 3'h1;
   localparam logic [2:0] SLOT_DE2 = 3'h2;
   localparam logic [2:0] SLOT_DE3 = 3'h3;
   localparam logic [2:0] SLOT_PAIR = 3'h4;
   localparam logic [2:0] SLOT_MAPA = 3'h5;
   localparam logic [2:0] SLOT_MAPB = 3'h6;

   // Output lane served by each de-emphasis slot, in address order
   localparam int SLOT_LANE [NLANES] = '{1, 0, 2, 3};

   // Field positions and reset values
   localparam int PAIR_BIT = 4;
   localparam int DE_HI = 7;
   localparam int DE_LO = 2;
   localparam logic [REG_W-1:0] RST_PAIR = 8'h80;
   localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
   localparam logic [SAMP_W-1:0] LANE_PAD = 8'h00;
   localparam logic [LANE_W-1:0] LANE_IDLE = 16'h0000;
   localparam logic [DATA_W-REG_W-1:0] RD_PAD = 24'h000000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } slcr_wr_t;

   typedef struct packed {
      logic hit;
      logic [2:0] slot;
   } slcr_dec_t;

   // Byte address to storage slot; misaligned or unknown addresses miss
   function automatic slcr_dec_t slcr_decode(input logic [ADDR_W-1:0] addr);
      slcr_dec_t d;
      logic [ADDR_W-1:0] idx;
      d.hit = 1'b1;
      d.slot = SLOT_DE0;
      idx = addr >> BYTE_SHIFT;
      if (addr[BYTE_SHIFT-1:0] != 2'h0) begin
         d.hit = 1'b0;
      end else begin
         case (idx)
            IDX_DEEMPH_S0: d.slot = SLOT_DE0;
            IDX_DEEMPH_S1: d.slot = SLOT_DE1;
            IDX_DEEMPH_S2: d.slot = SLOT_DE2;
            IDX_DEEMPH_S3: d.slot = SLOT_DE3;
            IDX_PAIRING: d.slot = SLOT_PAIR;
            IDX_MAP_A: d.slot = SLOT_MAPA;
            IDX_MAP_B: d.slot = SLOT_MAPB;
            default: d.hit = 1'b0;
         endcase
      end
      return d;
   endfunction
endpackage

// ---- src/slcr_regs.sv ----
// Register memory of the serial lane config block with registered read port
`timescale 1ns/1ps
module slcr_regs
   import slcr_pkg::*;
(
   // Clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Write port
   input wire logic we,
   input wire logic [2:0] wslot,
   input wire logic [REG_W-1:0] wdata,
   // Read port
   input wire logic re,
   input wire logic rhit,
   input wire logic [2:0] rslot,
   output logic [REG_W-1:0] rdata_r,
   // Stored contents
   output logic [NREGS-1:0][REG_W-1:0] q_r
);
   logic [NREGS-1:0][REG_W-1:0] q_nxt;
   logic [REG_W-1:0] rdata_nxt;

   // Next contents; a miss reads back zero
   always_comb begin
      q_nxt = q_r;
      rdata_nxt = rdata_r;
      if (we) begin
         q_nxt[wslot] = wdata;
      end
      if (re) begin
         rdata_nxt = rhit ? q_r[rslot] : RST_ZERO;
      end
   end

   // Storage; only the pairing register resets to a non-zero value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREGS; i++) begin
            q_r[i] <= (i == int'(SLOT_PAIR)) ? RST_PAIR : RST_ZERO;
         end
         rdata_r <= RST_ZERO;
      end else if (ce) begin
         q_r <= q_nxt;
         rdata_r <= rdata_nxt;
      end
   end
endmodule // slcr_regs

// ---- src/slcr_top.sv ----
// Serial lane configuration registers with AXI4-Lite slave and lane data steering
`timescale 1ns/1ps
// How it works
// - Pairing bit 4 set puts both channels on one shared lane.
// - Pairing bit clear gives each channel its own lane.
// - Each channel has an 8-bit read-write lane map code in bits 7-0.
// - Bits 7-2 of each lane register hold a thermometer de-emphasis code.
// - Four de-emphasis registers at consecutive addresses serve lanes 1, 0, 2, 3.
module slcr_top
   import slcr_pkg::*;
(
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W/8-1:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // Channel samples
   input wire logic [SAMP_W-1:0] ch_a_sample,
   input wire logic [SAMP_W-1:0] ch_b_sample,
   // Lane data and transmitter settings
   output logic [NLANES-1:0][LANE_W-1:0] lane_data,
   output logic [REG_W-1:0] chan_a_lane_map_code,
   output logic [REG_W-1:0] chan_b_lane_map_code,
   output logic [NLANES-1:0][DE_W-1:0] lane_deemphasis_code,
   output logic lane_share
);
   logic [NREGS-1:0][REG_W-1:0] q_r;
   logic [REG_W-1:0] rd_byte_r;
   slcr_wr_t wr_state_r, wr_state_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [REG_W-1:0] wbyte_r, wbyte_nxt;
   logic wlane_r, wlane_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic we;
   logic re;
   slcr_dec_t wdec, rdec;
   logic [NLANES-1:0][LANE_W-1:0] lane_r, lane_nxt;

   assign wdec = slcr_decode(waddr_r);
   assign rdec = slcr_decode(araddr);
   assign re = arvalid && arready_r;

   // Write channel: address and data taken in either order, reply after both
   always_comb begin
      wr_state_nxt = wr_state_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      waddr_nxt = waddr_r;
      wbyte_nxt = wbyte_r;
      wlane_nxt = wlane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      we = 1'b0;
      if (awvalid && awready_r) begin
         aw_got_nxt = 1'b1;
         waddr_nxt = awaddr;
      end
      if (wvalid && wready_r) begin
         w_got_nxt = 1'b1;
         wbyte_nxt = wdata[REG_W-1:0];
         wlane_nxt = wstrb[0];
      end
      case (wr_state_r)
         WR_IDLE: begin
            if (aw_got_r && w_got_r) begin
               // Byte lane 0 disabled means the write is acknowledged but dropped
               we = wdec.hit && wlane_r;
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               bvalid_nxt = 1'b1;
               bresp_nxt = wdec.hit ? RESP_OKAY : RESP_SLVERR;
               wr_state_nxt = WR_RESP;
            end
         end
         WR_RESP: begin
            if (bready) begin
               bvalid_nxt = 1'b0;
               wr_state_nxt = WR_IDLE;
            end
         end
         default: wr_state_nxt = WR_IDLE;
      endcase
      // Each ready stays low while its own half is held, so one write at a time
      awready_nxt = !aw_got_nxt && (wr_state_nxt == WR_IDLE) && !(aw_got_r && w_got_r);
      wready_nxt = !w_got_nxt && (wr_state_nxt == WR_IDLE) && !(aw_got_r && w_got_r);
   end

   // Read channel: data come from the memory read register one edge later
   always_comb begin
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      if (re) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = rdec.hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   // Bus state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r <= WR_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         waddr_r <= '0;
         wbyte_r <= RST_ZERO;
         wlane_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         wr_state_r <= wr_state_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         waddr_r <= waddr_nxt;
         wbyte_r <= wbyte_nxt;
         wlane_r <= wlane_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         // First cycle after reset raises arready
         arready_r <= rvalid_r ? arready_nxt : (arready_nxt || !re);
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Register memory; reserved bits are stored as written and read back
   slcr_regs u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .we(we),
      .wslot(wdec.slot),
      .wdata(wbyte_r),
      .re(re),
      .rhit(rdec.hit),
      .rslot(rdec.slot),
      .rdata_r(rd_byte_r),
      .q_r(q_r)
   );

   // Lane steering; pairing is trusted only in decimate-by-4, which software keeps
   always_comb begin
      lane_nxt = '{default: LANE_IDLE};
      if (q_r[SLOT_PAIR][PAIR_BIT]) begin
         lane_nxt[0] = {ch_a_sample, ch_b_sample};
      end else begin
         lane_nxt[0] = {LANE_PAD, ch_a_sample};
         lane_nxt[1] = {LANE_PAD, ch_b_sample};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lane_r <= '{default: LANE_IDLE};
      end else if (ce) begin
         lane_r <= lane_nxt;
      end
   end

   // Outputs straight from flops
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = {RD_PAD, rd_byte_r};
   assign lane_data = lane_r;
   assign lane_share = q_r[SLOT_PAIR][PAIR_BIT];
   assign chan_a_lane_map_code = q_r[SLOT_MAPA];
   assign chan_b_lane_map_code = q_r[SLOT_MAPB];

   // De-emphasis slots in address order feed lanes 1, 0, 2, 3
   generate
      for (genvar s = 0; s < NLANES; s++) begin : g_deemph
         assign lane_deemphasis_code[SLOT_LANE[s]] = q_r[s][DE_HI:DE_LO];
      end
   endgenerate

   AST_SHARED_LANE: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && lane_share) |=> lane_data[0] == {$past(ch_a_sample), $past(ch_b_sample)}
      && lane_data[1] == LANE_IDLE)
      else $error("shared lane does not carry both channels");

   AST_OWN_LANES: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !lane_share) |=> lane_data[0][SAMP_W-1:0] == $past(ch_a_sample)
      && lane_data[1][SAMP_W-1:0] == $past(ch_b_sample))
      else $error("channels not on separate lanes");

   AST_MAP_B_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && we && wdec.slot == SLOT_MAPB) |=> chan_b_lane_map_code == $past(wbyte_r))
      else $error("channel b map code not written");

   AST_DEEMPH_FIRST_SLOT: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && we && wdec.slot == SLOT_DE0)
      |=> lane_deemphasis_code[1] == $past(wbyte_r[DE_HI:DE_LO]))
      else $error("first de-emphasis register does not steer lane 1");

   AST_DEEMPH_SECOND_SLOT: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && we && wdec.slot == SLOT_DE1)
      |=> lane_deemphasis_code[0] == $past(wbyte_r[DE_HI:DE_LO])
      ##1 (!ce || we || $stable(lane_deemphasis_code[0])))
      else $error("second de-emphasis register does not steer lane 0");

   AST_PAIR_RESPONSE: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && we && wdec.slot == SLOT_PAIR) |=> bvalid && lane_share == $past(wbyte_r[PAIR_BIT]))
      else $error("pairing write not applied with response");
endmodule // slcr_top

// ---- verif/slcr_top_tb.sv ----
// Self-checking testbench of the serial lane configuration registers
`timescale 1ns/1ps
module slcr_top_tb;
   import slcr_pkg::*;
   // Bus and sample drive, all idle at time zero
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic [7:0] ch_a_sample = 8'h00;
   logic [7:0] ch_b_sample = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, lane_share;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0][15:0] lane_data;
   logic [7:0] chan_a_lane_map_code, chan_b_lane_map_code;
   logic [3:0][5:0] lane_deemphasis_code;
   // Reference model: stored bytes by slot, printed indices, lane of each slot
   int mem[7] = '{0, 0, 0, 0, 'h80, 0, 0};
   const int ix[7] = '{'h12, 'h13, 'h14, 'h15, 'h16, 'h31, 'h32};
   const int ln[4] = '{1, 0, 2, 3};
   int err_count = 0;
   int checked = 0;
   logic [31:0] seed = 32'h060f;

   slcr_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .ch_a_sample(ch_a_sample),
      .ch_b_sample(ch_b_sample), .lane_data(lane_data),
      .chan_a_lane_map_code(chan_a_lane_map_code),
      .chan_b_lane_map_code(chan_b_lane_map_code),
      .lane_deemphasis_code(lane_deemphasis_code), .lane_share(lane_share));

   // 20 MHz clock
   always #25 aclk = ~aclk;

   // Xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic conclude();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // Readies are looked at on the falling edge, so the handshake edge is the next rise
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s,
      output logic [1:0] r);
      logic pa, pw, ta, tw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= {4{s}};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge aclk); while (!bvalid);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   task automatic rd_all();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < NREGS; i++) begin
         rd(8'(ix[i] * 4), d, r);
         chk(d, mem[i], "rdata");
         chk(r, RESP_OKAY, "rresp");
      end
   endtask

   // Settings on the ports and lane words for one random sample pair
   task automatic chk_out();
      logic [7:0] a, b;
      logic [63:0] e;
      a = 8'(rnd());
      b = 8'(rnd());
      @(posedge aclk);
      ch_a_sample <= a;
      ch_b_sample <= b;
      @(posedge aclk);
      @(negedge aclk);
      e = mem[4][4] ? {48'h0, a, b} : {32'h0, 8'h00, b, 8'h00, a};
      chk(lane_data, e, "lanes");
      chk(lane_share, mem[4][4], "share");
      chk(chan_a_lane_map_code, mem[5], "mapa");
      chk(chan_b_lane_map_code, mem[6], "mapb");
      for (int k = 0; k < 4; k++) chk(lane_deemphasis_code[ln[k]], mem[k][7:2], "emph");
      // Enable low must freeze the lane words even though the samples move
      @(posedge aclk);
      ce <= 1'b0;
      ch_a_sample <= ~a;
      ch_b_sample <= ~b;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(lane_data, e, "frozen");
      @(posedge aclk);
      ce <= 1'b1;
   endtask

   // Main sequence
   initial begin
      logic [7:0] v;
      logic [31:0] d;
      logic [1:0] r;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd_all();
      chk_out();
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < NREGS; i++) begin
            v = 8'(rnd());
            if (i < 4) v = {6'h3f >> (p * 4 + i), i == 0, 1'b0};
            if (i == 4) v = {3'h4, p[0], 4'h0};
            wr(8'(ix[i] * 4), v, 1'b1, r);
            chk(r, RESP_OKAY, "bresp");
            mem[i] = v;
         end
         rd_all();
         chk_out();
      end
      // Unmapped and misaligned places answer with an error and hold nothing
      foreach (ix[i]) if (i < 2) begin
         v = i ? 8'h49 : 8'h5c;
         wr(v, 8'hff, 1'b1, r);
         chk(r, RESP_SLVERR, "bad bresp");
         rd(v, d, r);
         chk(d, 0, "bad rdata");
         chk(r, RESP_SLVERR, "bad rresp");
      end
      // Write with its low strobe off leaves the register alone; data differ from the store
      wr(8'h58, 8'h80, 1'b0, r);
      chk(r, RESP_OKAY, "strobe");
      rd_all();
      chk_out();
      // Second reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      mem = '{0, 0, 0, 0, 'h80, 0, 0};
      rd_all();
      chk_out();
      conclude();
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      conclude();
   end
endmodule // slcr_top_tb
